// ---- src/power_up_strap_latch.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "strap_latch_defs.svh"

module power_up_strap_latch #(
    parameter int PIN_COUNT = `STRAP_PIN_COUNT,
    parameter int SELECT_CYCLES = `STRAP_SELECT_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic supply_ok,
    input wire logic [PIN_COUNT-1:0] strap_pin_in,
    input wire logic [PIN_COUNT-1:0] clock_source,
    input wire logic cpu_pin_mask_unused,
    output logic [PIN_COUNT-1:0] strap_pin_out,
    output logic [PIN_COUNT-1:0] strap_pin_oe,
    output logic [PIN_COUNT-1:0] strap_value,
    output logic strap_valid,
    output logic spread_enable,
    output logic selecting
);
    localparam int CW = $clog2(SELECT_CYCLES + 1);

    // sequence overview, one step per line:
    // - rstn low stands for the supply being absent
    // - while rstn is low every output is forced to zero
    // - all pin drivers are therefore off during power loss
    // - after rstn rises the block waits for supply detect
    // - supply detect is a level from the analog power-on detector
    // - it is asynchronous, so it passes the pin synchroniser
    // - the synchroniser adds roughly four enabled cycles
    // - this delay only lengthens the selection window
    // - a longer window is safe; a shorter one is not
    // - once supply detect is seen, the timer is cleared
    // - the timer then counts select_cycles enabled cycles
    // - pins float for the whole count so straps settle
    // - strap resistors must charge the pin load in that time
    // - the count never stops early, whatever the pins do
    // - after the count the capture state takes one cycle
    // - capture copies the synchronised pin levels into the latch
    // - the valid flag rises in the same cycle as the latch
    // - drivers turn on one cycle after the valid flag
    // - so no driven level can ever be read back as a strap
    // - after capture the machine sits in run for good
    // - a drop of supply detect in run is ignored on purpose
    // - brown-out handling belongs to the reset generator
    // - reloading the straps needs rstn, i.e. a power cycle
    // - clock enable low freezes every flip-flop in the block
    // - the timer counts enabled cycles, not wall-clock time
    // - a caller that gates ce must lengthen the count to match

    // hazards and limits:
    // - pins must hold their level until capture
    // - the synchroniser needs stages two and three to agree
    // - a pin that toggles near capture may latch either level
    // - the clock source is passed through without alignment
    // - the first driven cycle can therefore be short
    // - downstream logic must accept one short first cycle
    // - spread modulation itself lives in the synthesizer
    // - this block only hands over the latched enable bit
    // - frequency select bits leave on strap_value unchanged

    // terminal count of the selection timer; shared by decode
    function automatic logic timer_done(input logic [CW-1:0] value);
        return value == CW'(SELECT_CYCLES - 1);
    endfunction : timer_done

    // gate a per-pin vector: zero until the drivers may run
    function automatic logic [PIN_COUNT-1:0] gate_pins(
        input logic enable,
        input logic [PIN_COUNT-1:0] value
    );
        return enable ? value : '0;
    endfunction : gate_pins

    // spread request taken from its strap bit once valid
    function automatic logic spread_from(
        input logic [PIN_COUNT-1:0] value,
        input logic valid
    );
        return value[`STRAP_SPREAD_BIT] & valid;
    endfunction : spread_from

    strap_latch_pkg::strap_state_t state;
    strap_latch_pkg::strap_state_t next_state;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic [PIN_COUNT-1:0] next_strap_value;
    logic next_strap_valid;
    logic [PIN_COUNT-1:0] next_strap_pin_out;
    logic [PIN_COUNT-1:0] next_strap_pin_oe;
    logic next_spread_enable;
    logic next_selecting;
    logic supply_sync;
    logic [PIN_COUNT-1:0] pin_sync;

    // supply detect and strap pins come from outside the clock domain
    strap_pin_sync #(
        .WIDTH(PIN_COUNT + 1)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .async_in({supply_ok, strap_pin_in}),
        .sync_out({supply_sync, pin_sync})
    );

    // power-up sequencing and latch control
    always_comb begin
        next_state = state;
        next_count = count;
        next_strap_value = strap_value;
        next_strap_valid = strap_valid;
        unique case (state)
            strap_latch_pkg::ST_WAIT_SUPPLY: begin
                if (supply_sync) begin
                    next_state = strap_latch_pkg::ST_SELECT;
                    next_count = '0;
                end
            end
            strap_latch_pkg::ST_SELECT: begin
                // pins stay undriven while counting
                // full count runs even if pins look settled early
                if (timer_done(count)) begin
                    next_state = strap_latch_pkg::ST_CAPTURE;
                end else begin
                    next_count = count + CW'(1);
                end
            end
            strap_latch_pkg::ST_CAPTURE: begin
                // pin level taken as is: low reads 0, high reads 1
                next_strap_value = pin_sync;
                next_strap_valid = 1'b1;
                next_state = strap_latch_pkg::ST_RUN;
            end
            strap_latch_pkg::ST_RUN: begin
                // no path out; only power removal (rstn) reloads
                next_state = strap_latch_pkg::ST_RUN;
            end
        endcase
    end

    // pin drivers follow the latch by one cycle so capture precedes driving
    always_comb begin
        next_selecting = (state == strap_latch_pkg::ST_SELECT);
        // drivers keyed off the registered flag, one cycle after latch
        next_strap_pin_oe = gate_pins(strap_valid, {PIN_COUNT{1'b1}});
        // clock passes unaligned; a short first cycle is tolerated
        next_strap_pin_out = gate_pins(strap_valid, clock_source);
        // spread gates modulation in the synthesizer for cpu and pci
        // taken from next values so it rises together with the latch
        next_spread_enable = spread_from(next_strap_value, next_strap_valid);
    end

    // all state and outputs registered here; ce low holds everything
    // reset values are constants only, so power loss clears cleanly
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= strap_latch_pkg::ST_WAIT_SUPPLY;
            count <= '0;
            strap_value <= `STRAP_LATCH_RESET;
            strap_valid <= 1'b0;
            strap_pin_out <= '0;
            strap_pin_oe <= '0;
            spread_enable <= 1'b0;
            selecting <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            count <= next_count;
            strap_value <= next_strap_value;
            strap_valid <= next_strap_valid;
            strap_pin_out <= next_strap_pin_out;
            strap_pin_oe <= next_strap_pin_oe;
            spread_enable <= next_spread_enable;
            selecting <= next_selecting;
        end
    end
endmodule : power_up_strap_latch

`default_nettype wire

// ---- src/strap_latch_defs.svh ----
`ifndef STRAP_LATCH_DEFS_SVH
`define STRAP_LATCH_DEFS_SVH

// number of dual-purpose strap pins
`define STRAP_PIN_COUNT 5
// clock rate in kHz and selection period in microseconds
`define STRAP_CLK_KHZ 25000
`define STRAP_SELECT_US 2000
// cycles in the selection period, at least the printed time
`define STRAP_SELECT_CYCLES ((`STRAP_SELECT_US * `STRAP_CLK_KHZ + 999) / 1000)
// latched strap reset value before capture
`define STRAP_LATCH_RESET 5'h00
// index of strap bit that enables spread modulation
`define STRAP_SPREAD_BIT 4

`endif

// ---- src/strap_latch_pkg.sv ----
package strap_latch_pkg;

    // power-up sequence, gray coded along the path
    typedef enum logic [1:0] {
        ST_WAIT_SUPPLY = 2'b00,
        ST_SELECT = 2'b01,
        ST_CAPTURE = 2'b11,
        ST_RUN = 2'b10
    } strap_state_t;

endpackage : strap_latch_pkg

// ---- src/strap_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser; output changes once stages two and three agree
module strap_pin_sync #(
    parameter int WIDTH = 5
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_sync_out;

    // a bit takes the new level only when the last two stages match
    always_comb begin
        next_sync_out = sync_out;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
                next_sync_out[i] = stage3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            sync_out <= '0;
        end else if (ce) begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
            sync_out <= next_sync_out;
        end
    end
endmodule : strap_pin_sync

`default_nettype wire

// ---- tb/power_up_strap_latch_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module strap_latch_sva #(parameter int PIN_COUNT = 5) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic supply_ok,
    input wire logic [PIN_COUNT-1:0] strap_pin_in,
    input wire logic [PIN_COUNT-1:0] clock_source,
    input wire logic [PIN_COUNT-1:0] strap_pin_out,
    input wire logic [PIN_COUNT-1:0] strap_pin_oe,
    input wire logic [PIN_COUNT-1:0] strap_value,
    input wire logic strap_valid,
    input wire logic spread_enable,
    input wire logic selecting
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // drivers stay off until levels are latched
    a_pins_floating: assert property (!strap_valid |-> strap_pin_oe == '0)
        else $error("pin driven before capture");
    a_oe_after_latch: assert property (strap_valid && !strap_pin_oe[0] && ce |=> &strap_pin_oe)
        else $error("drivers not enabled after capture");
    a_value_held: assert property (strap_valid |=> strap_valid && $stable(strap_value))
        else $error("latched value changed");
    a_capture_level: assert property ($rose(strap_valid) |-> strap_value == $past(strap_pin_in))
        else $error("captured level wrong");
    a_spread_bit: assert property (spread_enable == (strap_valid & strap_value[4]))
        else $error("spread enable mismatch");
    a_clock_out: assert property (strap_pin_oe[0] && ce |=> strap_pin_out == $past(clock_source))
        else $error("pin not carrying clock");
    a_select_min: assert property ($rose(selecting) |-> !strap_valid [*8])
        else $error("selection period short");
    a_timer_start: assert property ($rose(supply_ok) |-> ##[1:8] selecting)
        else $error("timer did not start");
    // main scenarios reached
    c_capture: cover property ($rose(strap_valid));
    c_drive: cover property ($rose(strap_pin_oe[0]));
    c_spread: cover property ($rose(spread_enable));
endmodule : strap_latch_sva
bind power_up_strap_latch strap_latch_sva #(.PIN_COUNT(PIN_COUNT)) u_sva (.*);
`default_nettype wire

// ---- tb/power_up_strap_latch_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module power_up_strap_latch_bench;
    logic clk = 0, rstn = 0, ce = 1, supply_ok = 0;
    logic [4:0] strap_pin_in = 5'h00, clock_source = 5'h00;
    logic [4:0] strap_pin_out, strap_pin_oe, strap_value;
    logic strap_valid, spread_enable, selecting;
    int err_count = 0, cmp_count = 0;
    always #20 clk = ~clk;
    // toggling sources so the pin drive path is exercised
    always @(posedge clk) clock_source <= ~clock_source;
    power_up_strap_latch #(.SELECT_CYCLES(8)) u_dut (.clk(clk), .rstn(rstn), .ce(ce),
        .supply_ok(supply_ok), .strap_pin_in(strap_pin_in), .clock_source(clock_source),
        .cpu_pin_mask_unused(1'b0), .strap_pin_out(strap_pin_out), .strap_pin_oe(strap_pin_oe),
        .strap_value(strap_value), .strap_valid(strap_valid), .spread_enable(spread_enable),
        .selecting(selecting));
    task automatic check(input string name, input logic [4:0] exp, input logic [4:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic finish_test;
        if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // full power cycle: strap, raise supply, capture, then disturb the pins
    task automatic power_cycle(input logic [4:0] pins);
        int n;
        @(posedge clk) rstn <= 0;
        strap_pin_in <= pins;
        supply_ok <= 0;
        repeat (12) @(posedge clk);
        rstn <= 1;
        @(posedge clk) supply_ok <= 1;
        n = 0;
        // bounded wait; a hang shows up as a failed capture below
        while (strap_valid !== 1'b1 && n < 40) begin
            @(negedge clk);
            check("oe floating", 5'h00, strap_pin_oe);
            check("out low", 5'h00, strap_pin_out);
            n++;
        end
        check("valid", 5'h01, {4'h0, strap_valid});
        check("value", pins, strap_value);
        check("spread", {4'h0, pins[4]}, {4'h0, spread_enable});
        @(negedge clk);
        check("oe", 5'h1f, strap_pin_oe);
        check("selecting", 5'h00, {4'h0, selecting});
        @(negedge clk);
        check("pin clock", ~clock_source, strap_pin_out);
        @(posedge clk) strap_pin_in <= ~pins;
        repeat (10) @(negedge clk);
        check("held", pins, strap_value);
    endtask : power_cycle
    initial begin
        repeat (12) @(posedge clk);
        power_cycle(5'h15);
        power_cycle(5'h0a);
        power_cycle(5'h1f);
        power_cycle(5'h00);
        finish_test();
    end
    // watchdog: about seventeen times the expected run
    initial begin
        #(40 * 3000);
        err_count++;
        finish_test();
    end
endmodule : power_up_strap_latch_bench
`default_nettype wire
